// ### inc/osl_pkg.sv
// constants and carrier types for the output setpoint and limit registers
package osl_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_PAGES = 2;
	localparam int DATA_W = 16;

	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_FORMAT = 8'h20;
	localparam logic [7:0] CMD_CAL = 8'h23;
	localparam logic [7:0] CMD_CEIL = 8'h24;
	localparam logic [7:0] CMD_MHI = 8'h25;
	localparam logic [7:0] CMD_MLO = 8'h26;

	// ==========================================================
	// values
	// linear mode, exponent -13 in five-bit two's complement
	localparam logic [15:0] FORMAT_VALUE = 16'h0013;
	localparam logic [15:0] CAL_RESET = 16'h0000;
	// strap multipliers, q16 fixed point
	localparam int SCALE_SHIFT = 16;
	localparam logic [16:0] SCALE_CEIL = 17'h12666;
	localparam logic [16:0] SCALE_MHI = 17'h10ccd;
	localparam logic [16:0] SCALE_MLO = 17'h0f333;
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		OSL_NOMINAL,
		OSL_MARGIN_LOW,
		OSL_MARGIN_HIGH
	} osl_mode_e;

	typedef enum logic [1:0] {
		OSL_SETTLE,
		OSL_LOAD,
		OSL_RUN
	} osl_state_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [0:0] page;
		logic [7:0] code;
		logic [15:0] wdata;
	} osl_cmd_s;

	typedef struct packed {
		logic valid;
		logic ack;
		logic [15:0] data;
	} osl_rsp_s;

	// strap value times a q16 factor, saturated to 16 bits
	function automatic logic [15:0] osl_scale(input logic [15:0] v, input logic [16:0] k);
		logic [32:0] prod;
		prod = 33'(v) * 33'(k);
		if (prod[32:SCALE_SHIFT] > 17'h0ffff) begin
			return 16'hffff;
		end
		return prod[SCALE_SHIFT +: DATA_W];
	endfunction

endpackage

// ### verification/osl_host.sv
// bus host model issuing whole-word requests to the setpoint registers
`timescale 1ns/1ns
module osl_host
	import osl_pkg::*;
(
	input wire logic clk_in,
	input wire logic ready_in,
	input wire osl_rsp_s rsp_in,
	output osl_cmd_s cmd_out
);
	initial cmd_out = '0;
	// request held until taken or for at most 50 edges; idle lines show inverted last values
	task automatic xfer(input logic w, input logic pg, input logic [7:0] c,
		input logic [15:0] wd, output logic ack, output logic [15:0] rd);
		int n;
		n = 0;
		cmd_out <= '{valid: 1'b1, write: w, page: pg, code: c, wdata: wd};
		do begin
			@(posedge clk_in);
			n++;
		end while (ready_in !== 1'b1 && n < 50);
		cmd_out <= '{valid: 1'b0, write: ~w, page: ~pg, code: ~c, wdata: ~wd};
		// answer stands in the cycle after the taken edge
		@(posedge clk_in);
		ack = rsp_in.valid ? rsp_in.ack : 1'bx;
		rd = rsp_in.data;
	endtask
endmodule

// ### verification/osl_regs_tb.sv
// self-checking bench for the output setpoint and limit registers
`timescale 1ns/1ns
module osl_regs_tb
	import osl_pkg::*;
;
	logic clk_sys_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [1:0][15:0] strap = {16'h1800, 16'h2000};
	logic [1:0][15:0] tgt = {16'h1800, 16'h2000};
	osl_mode_e [1:0] mode = {OSL_NOMINAL, OSL_NOMINAL};
	osl_cmd_s cmd;
	logic ready;
	osl_rsp_s rsp;
	logic [1:0][15:0] reference_out;
	logic [1:0] ceiling_hit_out;
	int bad_count = 0;
	int tests_run = 0;
	int cycles = 0;

	always #20 clk_sys_in = ~clk_sys_in;

	osl_regs i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.pinstrap_voltage_setting_in(strap), .output_voltage_target_in(tgt),
		.op_mode_in(mode), .cmd_in(cmd), .cmd_ready_out(ready), .rsp_out(rsp),
		.reference_out(reference_out), .ceiling_hit_out(ceiling_hit_out));
	osl_host i_host (.clk_in(clk_sys_in), .ready_in(ready), .rsp_in(rsp), .cmd_out(cmd));

	// ==========================================================
	// tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic acc(input logic w, input logic pg, input logic [7:0] c,
		input logic [15:0] wd, input logic ea, input logic [15:0] ed);
		logic a;
		logic [15:0] d;
		i_host.xfer(w, pg, c, wd, a, d);
		chk("ack", 16'(ea), 16'(a));
		if (!w) chk("read data", ed, d);
	endtask

	task automatic ref_chk(input logic pg, input logic [15:0] e, input logic h);
		repeat (3) @(posedge clk_sys_in);
		chk("reference", e, reference_out[pg]);
		chk("ceiling hit", 16'(h), 16'(ceiling_hit_out[pg]));
	endtask

	function automatic logic [15:0] sc(input logic [15:0] v, input logic [16:0] k);
		return 16'((34'(v) * 34'(k)) >> 16);
	endfunction

	// ==========================================================
	// timeout
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			summarize();
		end
	end

	// ==========================================================
	// sequence
	initial begin
		repeat (2) @(posedge clk_sys_in);
		chk("ready in reset", 16'h0000, 16'(ready));
		sys_rst_in <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			acc(1'b0, p[0], CMD_CAL, 16'h0000, 1'b1, CAL_RESET);
			acc(1'b0, p[0], CMD_CEIL, 16'h0000, 1'b1, sc(strap[p], SCALE_CEIL));
			acc(1'b0, p[0], CMD_MHI, 16'h0000, 1'b1, sc(strap[p], SCALE_MHI));
			acc(1'b0, p[0], CMD_MLO, 16'h0000, 1'b1, sc(strap[p], SCALE_MLO));
			acc(1'b0, p[0], CMD_FORMAT, 16'h0000, 1'b1, 16'h0013);
			ref_chk(p[0], tgt[p], 1'b0);
		end
		acc(1'b1, 1'b0, CMD_FORMAT, 16'h0000, 1'b0, 16'h0000);
		acc(1'b0, 1'b0, CMD_FORMAT, 16'h0000, 1'b1, 16'h0013);
		acc(1'b0, 1'b0, 8'h27, 16'h0000, 1'b0, 16'h0000);
		acc(1'b1, 1'b1, CMD_CAL, 16'h0040, 1'b1, 16'h0000);
		acc(1'b0, 1'b0, CMD_CAL, 16'h0000, 1'b1, 16'h0000);
		acc(1'b0, 1'b1, CMD_CAL, 16'h0000, 1'b1, 16'h0040);
		ref_chk(1'b1, 16'h1840, 1'b0);
		mode[0] <= OSL_MARGIN_HIGH;
		acc(1'b1, 1'b0, CMD_MHI, 16'h2100, 1'b1, 16'h0000);
		ref_chk(1'b0, 16'h2100, 1'b0);
		mode[0] <= OSL_MARGIN_LOW;
		acc(1'b1, 1'b0, CMD_MLO, 16'h1e00, 1'b1, 16'h0000);
		ref_chk(1'b0, 16'h1e00, 1'b0);
		acc(1'b1, 1'b0, CMD_CAL, 16'hff00, 1'b1, 16'h0000);
		ref_chk(1'b0, 16'h1d00, 1'b0);
		mode[0] <= OSL_NOMINAL;
		tgt[0] <= 16'h3000;
		ref_chk(1'b0, sc(strap[0], SCALE_CEIL), 1'b1);
		acc(1'b0, 1'b0, CMD_CEIL, 16'h0000, 1'b1, sc(strap[0], SCALE_CEIL));
		acc(1'b1, 1'b0, CMD_CEIL, 16'h3100, 1'b1, 16'h0000);
		ref_chk(1'b0, 16'h2f00, 1'b0);
		acc(1'b1, 1'b0, CMD_MHI, 16'hffff, 1'b1, 16'h0000);
		acc(1'b0, 1'b0, CMD_MHI, 16'h0000, 1'b1, 16'hffff);
		acc(1'b1, 1'b0, CMD_CAL, 16'h0000, 1'b1, 16'h0000);
		mode[0] <= OSL_MARGIN_HIGH;
		ref_chk(1'b0, 16'h3100, 1'b1);
		acc(1'b1, 1'b0, CMD_CEIL, 16'hffff, 1'b1, 16'h0000);
		acc(1'b1, 1'b0, CMD_CAL, 16'h0040, 1'b1, 16'h0000);
		mode[0] <= OSL_NOMINAL;
		ref_chk(1'b0, 16'h3040, 1'b0);
		// second reset brings the strap defaults back
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		acc(1'b0, 1'b0, CMD_CEIL, 16'h0000, 1'b1, sc(strap[0], SCALE_CEIL));
		acc(1'b0, 1'b0, CMD_CAL, 16'h0000, 1'b1, CAL_RESET);
		acc(1'b0, 1'b1, CMD_MLO, 16'h0000, 1'b1, sc(strap[1], SCALE_MLO));
		summarize();
	end
endmodule

// ### verilog/osl_clamp.sv
// target selection, offset correction and ceiling clamp for one page
`timescale 1ns/1ns
module osl_clamp
	import osl_pkg::*;
(
	input wire osl_mode_e mode_in,
	input wire logic [15:0] nominal_in,
	input wire logic [15:0] mhi_in,
	input wire logic [15:0] mlo_in,
	input wire logic [15:0] cal_in,
	input wire logic [15:0] ceil_in,
	output logic [15:0] ref_out,
	output logic limited_out
);
	logic [15:0] sel;
	logic signed [17:0] sum;

	always_comb begin
		unique case (mode_in)
			OSL_MARGIN_HIGH: sel = mhi_in;
			OSL_MARGIN_LOW: sel = mlo_in;
			OSL_NOMINAL: sel = nominal_in;
			default: sel = nominal_in;
		endcase
		// signed offset in the same lsb
		sum = $signed({2'h0, sel}) + 18'($signed(cal_in));
		limited_out = 1'b0;
		if (sum < 0) begin
			ref_out = 16'h0000;
		end else if (sum > $signed({2'h0, ceil_in})) begin
			ref_out = ceil_in;
			limited_out = 1'b1;
		end else begin
			ref_out = sum[15:0];
		end
	end
endmodule

// ### verilog/osl_regs.sv
// paged output setpoint, offset and ceiling registers with target clamp
`timescale 1ns/1ns
module osl_regs
	import osl_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [NUM_PAGES-1:0][15:0] pinstrap_voltage_setting_in,
	input wire logic [NUM_PAGES-1:0][15:0] output_voltage_target_in,
	input wire osl_mode_e [NUM_PAGES-1:0] op_mode_in,
	input wire osl_cmd_s cmd_in,
	output logic cmd_ready_out,
	output osl_rsp_s rsp_out,
	output logic [NUM_PAGES-1:0][15:0] reference_out,
	output logic [NUM_PAGES-1:0] ceiling_hit_out
);

	// ==========================================================
	// state
	typedef struct packed {
		osl_state_e st;
		logic [1:0] settle;
		logic [NUM_PAGES-1:0][15:0] strap_s1;
		logic [NUM_PAGES-1:0][15:0] strap_s2;
		logic [NUM_PAGES-1:0][15:0] output_calibration_offset;
		logic [NUM_PAGES-1:0][15:0] output_voltage_ceiling;
		logic [NUM_PAGES-1:0][15:0] upper_margin_setpoint;
		logic [NUM_PAGES-1:0][15:0] lower_margin_setpoint;
		logic [NUM_PAGES-1:0][15:0] refv;
		logic [NUM_PAGES-1:0] hit;
		osl_rsp_s rsp;
	} osl_regs_s;

	osl_regs_s s;
	osl_regs_s next_s;
	logic accept;
	logic [NUM_PAGES-1:0][15:0] clamp_ref;
	logic [NUM_PAGES-1:0] clamp_hit;

	// true for codes this bank answers to
	function automatic logic code_known(input logic [7:0] code);
		return (code == CMD_FORMAT) || (code == CMD_CAL) || (code == CMD_CEIL) ||
			(code == CMD_MHI) || (code == CMD_MLO);
	endfunction

	// ==========================================================
	// per-page reference path
	for (genvar p = 0; p < NUM_PAGES; p++) begin : g_page
		osl_clamp u_clamp (
			.mode_in(op_mode_in[p]),
			.nominal_in(output_voltage_target_in[p]),
			.mhi_in(s.upper_margin_setpoint[p]),
			.mlo_in(s.lower_margin_setpoint[p]),
			.cal_in(s.output_calibration_offset[p]),
			.ceil_in(s.output_voltage_ceiling[p]),
			.ref_out(clamp_ref[p]),
			.limited_out(clamp_hit[p])
		);
	end

	assign accept = cmd_in.valid && (s.st == OSL_RUN);
	assign cmd_ready_out = (s.st == OSL_RUN);
	assign rsp_out = s.rsp;
	assign reference_out = s.refv;
	assign ceiling_hit_out = s.hit;

	// ==========================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.strap_s1 = pinstrap_voltage_setting_in;
		next_s.strap_s2 = s.strap_s1;
		next_s.rsp.valid = 1'b0;
		// reference held at zero until the strap defaults are loaded
		next_s.refv = '0;
		next_s.hit = '0;
		if (s.st == OSL_RUN) begin
			next_s.refv = clamp_ref;
			next_s.hit = clamp_hit;
		end
		unique case (s.st)
			OSL_SETTLE: begin
				next_s.settle = s.settle + 2'h1;
				if (s.settle == SETTLE_CYCLES) begin
					next_s.st = OSL_LOAD;
				end
			end
			OSL_LOAD: begin
				for (int p = 0; p < NUM_PAGES; p++) begin
					next_s.output_calibration_offset[p] = CAL_RESET;
					next_s.output_voltage_ceiling[p] = osl_scale(s.strap_s2[p], SCALE_CEIL);
					next_s.upper_margin_setpoint[p] = osl_scale(s.strap_s2[p], SCALE_MHI);
					next_s.lower_margin_setpoint[p] = osl_scale(s.strap_s2[p], SCALE_MLO);
				end
				next_s.st = OSL_RUN;
			end
			OSL_RUN: begin
				if (accept) begin
					next_s.rsp.valid = 1'b1;
					next_s.rsp.ack = code_known(cmd_in.code);
					next_s.rsp.data = 16'h0000;
					if (cmd_in.write) begin
						next_s.rsp.ack = code_known(cmd_in.code) && (cmd_in.code != CMD_FORMAT);
						// write reaches the selected page only
						unique case (cmd_in.code)
							CMD_CAL: next_s.output_calibration_offset[cmd_in.page] = cmd_in.wdata;
							// plain store, nothing else rescales it
							CMD_CEIL: next_s.output_voltage_ceiling[cmd_in.page] = cmd_in.wdata;
							CMD_MHI: next_s.upper_margin_setpoint[cmd_in.page] = cmd_in.wdata;
							CMD_MLO: next_s.lower_margin_setpoint[cmd_in.page] = cmd_in.wdata;
							default: ;
						endcase
					end else begin
						unique case (cmd_in.code)
							CMD_FORMAT: next_s.rsp.data = FORMAT_VALUE;
							CMD_CAL: next_s.rsp.data = s.output_calibration_offset[cmd_in.page];
							CMD_CEIL: next_s.rsp.data = s.output_voltage_ceiling[cmd_in.page];
							CMD_MHI: next_s.rsp.data = s.upper_margin_setpoint[cmd_in.page];
							CMD_MLO: next_s.rsp.data = s.lower_margin_setpoint[cmd_in.page];
							default: next_s.rsp.data = 16'h0000;
						endcase
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			s <= '0;
			s.st <= OSL_SETTLE;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	sequence rd_acc(logic [7:0] c);
		accept && !cmd_in.write && (cmd_in.code == c);
	endsequence

	sequence wr_acc(logic [7:0] c);
		accept && cmd_in.write && (cmd_in.code == c);
	endsequence

	ref_ceiling_a: assert property (
		(s.st == OSL_RUN) |=> (s.refv[0] <= $past(s.output_voltage_ceiling[0])))
		else $error("reference above ceiling");

	answer_next_a: assert property (
		accept |=> s.rsp.valid ##1 !s.rsp.valid || $past(accept))
		else $error("answer timing wrong");

	format_read_a: assert property (
		rd_acc(CMD_FORMAT) |=> (s.rsp.data == FORMAT_VALUE) && s.rsp.ack)
		else $error("format descriptor wrong");

	cal_readback_a: assert property (
		rd_acc(CMD_CAL) |=> s.rsp.ack &&
		(s.rsp.data == $past(s.output_calibration_offset[cmd_in.page])))
		else $error("offset read back differs");

	cal_store_a: assert property (
		wr_acc(CMD_CAL) |=>
		(s.output_calibration_offset[$past(cmd_in.page)] == $past(cmd_in.wdata)) &&
		(s.output_calibration_offset[~$past(cmd_in.page)] ==
		$past(s.output_calibration_offset[~cmd_in.page])))
		else $error("offset not stored in its page");

	mhi_store_a: assert property (
		wr_acc(CMD_MHI) |=> s.upper_margin_setpoint[$past(cmd_in.page)] == $past(cmd_in.wdata))
		else $error("margin-high not stored");

	mlo_store_a: assert property (
		wr_acc(CMD_MLO) |=> s.lower_margin_setpoint[$past(cmd_in.page)] == $past(cmd_in.wdata))
		else $error("margin-low not stored");

	ceil_default_a: assert property (
		(s.st == OSL_LOAD) |=>
		s.output_voltage_ceiling[0] == osl_scale($past(s.strap_s2[0]), SCALE_CEIL))
		else $error("ceiling default wrong");

	mhi_default_a: assert property (
		(s.st == OSL_LOAD) |=>
		s.upper_margin_setpoint[1] == osl_scale($past(s.strap_s2[1]), SCALE_MHI))
		else $error("margin-high default wrong");

	mlo_default_a: assert property (
		(s.st == OSL_LOAD) |=>
		s.lower_margin_setpoint[0] == osl_scale($past(s.strap_s2[0]), SCALE_MLO))
		else $error("margin-low default wrong");

	offset_add_a: assert property (
		(s.st == OSL_RUN) && (op_mode_in[0] == OSL_NOMINAL) &&
		(output_voltage_target_in[0] < 16'h4000) &&
		(s.output_calibration_offset[0] < 16'h0800) &&
		(s.output_voltage_ceiling[0] == 16'hffff)
		|=> s.refv[0] == $past(output_voltage_target_in[0]) + $past(s.output_calibration_offset[0]))
		else $error("offset not added");

	high_clamp_a: assert property (
		(s.st == OSL_RUN) && (op_mode_in[0] == OSL_MARGIN_HIGH) &&
		(s.output_calibration_offset[0] == 16'h0000) &&
		(s.upper_margin_setpoint[0] > s.output_voltage_ceiling[0])
		|=> (s.refv[0] == $past(s.output_voltage_ceiling[0])) && s.hit[0])
		else $error("target not clamped");

	ceil_steady_a: assert property (
		(s.st == OSL_RUN) && !(accept && cmd_in.write && cmd_in.code == CMD_CEIL)
		|=> $stable(s.output_voltage_ceiling))
		else $error("ceiling changed unasked");

endmodule
